// ---- fmc_top.sv ----
// Frame metadata counters: time stamp, trigger counter and line snapshot.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module fmc_top
    import fmc_pkg::*;
#(
    parameter int unsigned N_IN  = 4,
    parameter int unsigned N_OUT = 4
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    input  wire logic              acq_trigger,
    input  wire logic              ext_frame_trigger,
    input  wire logic [N_IN-1:0]   in_lines,
    input  wire logic [N_OUT-1:0]  out_lines,
    output logic                   meta_valid,
    output logic      [63:0]       meta_time_stamp,
    output logic      [31:0]       meta_trig_count,
    output logic      [31:0]       meta_line_status,
    output logic      [2:0]        meta_item_valid
);

    // Refuses line counts that leave no two clear lines or overflow the 32-bit snapshot.
    if (N_IN < 2 || N_IN + N_OUT > 32) begin : g_bad_lines
        $error("Line counts must give at least two inputs and fit 32 bits.");
    end

    function automatic logic agree_rise(input logic [2:0] s, input logic last);
        agree_rise = (s[1] == s[2]) && s[2] && !last;
    endfunction

    logic               mode_on_q;
    logic [1:0]         item_sel_q;
    logic [2:0]         item_on_q;
    logic [1:0]         cnt_sel_q;
    logic [1:0]         cnt_evt_q;
    fmc_clr_src_t       clr_src_q;
    logic               trig_on_q;
    logic               sw_clear_q;
    logic [63:0]        tick_q;
    logic [31:0]        trig_cnt_q;
    logic [63:0]        stamp_q;
    logic [31:0]        line_q;
    logic [$clog2(TICK_DIV+1)-1:0] div_q;
    logic               tick_en;
    logic [2:0]         l1_sync_q;
    logic [2:0]         l2_sync_q;
    logic [2:0]         et_sync_q;
    logic [2:0]         ac_sync_q;
    logic [N_IN+N_OUT-1:0] s1_q;
    logic [N_IN+N_OUT-1:0] s2_q;
    logic [N_IN+N_OUT-1:0] s3_q;
    logic [N_IN+N_OUT-1:0] lines_q;
    logic               l1_last_q;
    logic               l2_last_q;
    logic               et_last_q;
    logic               ac_last_q;
    logic               l1_rise;
    logic               l2_rise;
    logic               et_rise;
    logic               ac_rise;
    logic               line_clear;
    logic [2:0]         items_live;

    // Configuration registers written over the register port.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_on_q  <= 1'b0;
            item_sel_q <= ITEM_TIME_STAMP;
            item_on_q  <= 3'h0;
            cnt_sel_q  <= CNT_UNIT_FIRST;
            cnt_evt_q  <= EVT_FRAME_TRIG;
            clr_src_q  <= FMC_CLR_OFF;
            trig_on_q  <= 1'b0;
            sw_clear_q <= 1'b0;
        end else begin
            sw_clear_q <= 1'b0;
            if (reg_wr) begin
                if (reg_addr == ADDR_MODE) begin
                    mode_on_q <= reg_wdata[0];
                end else if (reg_addr == ADDR_ITEM_SEL) begin
                    item_sel_q <= reg_wdata[1:0];
                end else if (reg_addr == ADDR_ITEM_ON) begin
                    if (mode_on_q && item_sel_q <= ITEM_LINE_STAT) begin
                        item_on_q[item_sel_q] <= reg_wdata[0];
                    end
                end else if (reg_addr == ADDR_CNT_SEL) begin
                    cnt_sel_q <= reg_wdata[1:0];
                end else if (reg_addr == ADDR_CNT_EVT) begin
                    cnt_evt_q <= reg_wdata[1:0];
                end else if (reg_addr == ADDR_CLR_SRC) begin
                    if (cnt_sel_q == CNT_UNIT_FIRST && cnt_evt_q == EVT_FRAME_TRIG) begin
                        clr_src_q <= fmc_clr_src_t'(reg_wdata[1:0]);
                    end
                end else if (reg_addr == ADDR_CLR_CMD) begin
                    sw_clear_q <= (clr_src_q == FMC_CLR_SOFTWARE);
                end else if (reg_addr == ADDR_TRIG_ON) begin
                    trig_on_q <= reg_wdata[0];
                end
            end
        end
    end

    // Enables only count while append mode is on.
    assign items_live = mode_on_q ? item_on_q : 3'h0;

    // Register read port with data one cycle after the strobe.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            if (reg_addr == ADDR_MODE) begin
                reg_rdata <= {31'h0, mode_on_q};
            end else if (reg_addr == ADDR_ITEM_SEL) begin
                reg_rdata <= {30'h0, item_sel_q};
            end else if (reg_addr == ADDR_ITEM_ON) begin
                reg_rdata <= {29'h0, items_live};
            end else if (reg_addr == ADDR_CNT_SEL) begin
                reg_rdata <= {30'h0, cnt_sel_q};
            end else if (reg_addr == ADDR_CNT_EVT) begin
                reg_rdata <= {30'h0, cnt_evt_q};
            end else if (reg_addr == ADDR_CLR_SRC) begin
                reg_rdata <= {30'h0, clr_src_q};
            end else if (reg_addr == ADDR_TRIG_ON) begin
                reg_rdata <= {31'h0, trig_on_q};
            end else if (reg_addr == ADDR_TICK_LO) begin
                reg_rdata <= tick_q[31:0];
            end else if (reg_addr == ADDR_TICK_HI) begin
                reg_rdata <= tick_q[63:32];
            end else if (reg_addr == ADDR_TRIG_CNT) begin
                reg_rdata <= trig_on_q ? trig_cnt_q : 32'h0;
            end else if (reg_addr == ADDR_LINE_STAT) begin
                reg_rdata <= line_q;
            end else if (reg_addr == ADDR_STAMP_LO) begin
                reg_rdata <= stamp_q[31:0];
            end else if (reg_addr == ADDR_STAMP_HI) begin
                reg_rdata <= stamp_q[63:32];
            end else begin
                reg_rdata <= 32'h0;
            end
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // Three-stage synchronisers for every pin input.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            l1_sync_q <= 3'h0;
            l2_sync_q <= 3'h0;
            et_sync_q <= 3'h0;
            ac_sync_q <= 3'h0;
            s1_q      <= '0;
            s2_q      <= '0;
            s3_q      <= '0;
            l1_last_q <= 1'b0;
            l2_last_q <= 1'b0;
            et_last_q <= 1'b0;
            ac_last_q <= 1'b0;
        end else begin
            l1_sync_q <= {l1_sync_q[1:0], in_lines[0]};
            l2_sync_q <= {l2_sync_q[1:0], in_lines[1]};
            et_sync_q <= {et_sync_q[1:0], ext_frame_trigger};
            ac_sync_q <= {ac_sync_q[1:0], acq_trigger};
            s1_q      <= {out_lines, in_lines};
            s2_q      <= s1_q;
            s3_q      <= s2_q;
            if (l1_sync_q[1] == l1_sync_q[2]) l1_last_q <= l1_sync_q[2];
            if (l2_sync_q[1] == l2_sync_q[2]) l2_last_q <= l2_sync_q[2];
            if (et_sync_q[1] == et_sync_q[2]) et_last_q <= et_sync_q[2];
            if (ac_sync_q[1] == ac_sync_q[2]) ac_last_q <= ac_sync_q[2];
        end
    end

    // Each line level is taken over only once the second and third stages agree.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lines_q <= '0;
        end else begin
            lines_q <= (s2_q & s3_q) | (lines_q & (s2_q ^ s3_q));
        end
    end

    assign l1_rise = agree_rise(l1_sync_q, l1_last_q);
    assign l2_rise = agree_rise(l2_sync_q, l2_last_q);
    assign et_rise = agree_rise(et_sync_q, et_last_q);
    assign ac_rise = agree_rise(ac_sync_q, ac_last_q);

    // Line clear on a synchronized rising edge of the chosen input line.
    assign line_clear = (clr_src_q == FMC_CLR_LINE1 && l1_rise) ||
                        (clr_src_q == FMC_CLR_LINE2 && l2_rise);

    // Tick enable divider and free-running 64-bit tick counter.
    assign tick_en = (div_q == TICK_DIV[$bits(div_q)-1:0] - 1'b1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q  <= '0;
            tick_q <= TICK_RESET;
        end else begin
            div_q <= tick_en ? '0 : div_q + 1'b1;
            if (tick_en) begin
                tick_q <= tick_q + 64'h1;
            end
        end
    end

    // External trigger counter with selectable clear.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_cnt_q <= TRIG_CNT_RESET;
        end else if (line_clear || sw_clear_q) begin
            trig_cnt_q <= TRIG_CNT_RESET;
        end else if (trig_on_q && et_rise) begin
            trig_cnt_q <= trig_cnt_q + 32'h1;
        end
    end

    // Snapshot of stamp and lines at each acquisition trigger, then append.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stamp_q          <= 64'h0;
            line_q           <= 32'h0;
            meta_valid       <= 1'b0;
            meta_time_stamp  <= 64'h0;
            meta_trig_count  <= 32'h0;
            meta_line_status <= 32'h0;
            meta_item_valid  <= 3'h0;
        end else begin
            meta_valid <= 1'b0;
            if (ac_rise) begin
                stamp_q          <= tick_q;
                line_q           <= 32'(lines_q);
                meta_valid       <= 1'b1;
                meta_item_valid  <= {items_live[2], items_live[1] & trig_on_q, items_live[0]};
                meta_time_stamp  <= items_live[ITEM_TIME_STAMP] ? tick_q : 64'h0;
                meta_trig_count  <= (items_live[ITEM_TRIG_COUNT] && trig_on_q) ? trig_cnt_q : 32'h0;
                meta_line_status <= items_live[ITEM_LINE_STAT] ? 32'(lines_q) : 32'h0;
            end
        end
    end

endmodule
`default_nettype wire

// ---- fmc_pkg.sv ----
// Shared constants and types for the frame metadata counters.
package fmc_pkg;

    // Time-tick period and derived enable divider at the 50 MHz system clock.
    localparam int unsigned CLK_PERIOD_PS  = 20000;
    localparam int unsigned TICK_PERIOD_PS = 8000;
    localparam int unsigned TICK_DIV       = (TICK_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Register offsets.
    localparam logic [7:0] ADDR_MODE       = 8'h00;
    localparam logic [7:0] ADDR_ITEM_SEL   = 8'h04;
    localparam logic [7:0] ADDR_ITEM_ON    = 8'h08;
    localparam logic [7:0] ADDR_CNT_SEL    = 8'h0c;
    localparam logic [7:0] ADDR_CNT_EVT    = 8'h10;
    localparam logic [7:0] ADDR_CLR_SRC    = 8'h14;
    localparam logic [7:0] ADDR_CLR_CMD    = 8'h18;
    localparam logic [7:0] ADDR_TRIG_ON    = 8'h1c;
    localparam logic [7:0] ADDR_TICK_LO    = 8'h20;
    localparam logic [7:0] ADDR_TICK_HI    = 8'h24;
    localparam logic [7:0] ADDR_TRIG_CNT   = 8'h28;
    localparam logic [7:0] ADDR_LINE_STAT  = 8'h2c;
    localparam logic [7:0] ADDR_STAMP_LO   = 8'h30;
    localparam logic [7:0] ADDR_STAMP_HI   = 8'h34;

    // Item selector codes and bit positions in the enable word.
    localparam logic [1:0] ITEM_TIME_STAMP = 2'h0;
    localparam logic [1:0] ITEM_TRIG_COUNT = 2'h1;
    localparam logic [1:0] ITEM_LINE_STAT  = 2'h2;

    // Counter instance and event source codes that arm the trigger counter clear.
    localparam logic [1:0] CNT_UNIT_FIRST   = 2'h0;
    localparam logic [1:0] EVT_FRAME_TRIG   = 2'h1;

    // Reset values.
    localparam logic [63:0] TICK_RESET     = 64'h0;
    localparam logic [31:0] TRIG_CNT_RESET = 32'h0;

    typedef enum logic [1:0] {
        FMC_CLR_LINE1,
        FMC_CLR_LINE2,
        FMC_CLR_SOFTWARE,
        FMC_CLR_OFF
    } fmc_clr_src_t;

endpackage

// ---- fmc_top_asserts.sv ----
// Port checks for the frame metadata counters.
`timescale 1ns/1ns
`default_nettype none
module fmc_top_chk #(
    parameter int unsigned N_IN  = 4,
    parameter int unsigned N_OUT = 4
) (
    input wire logic             clk,
    input wire logic             rst_n,
    input wire logic             acq_trigger,
    input wire logic [N_IN-1:0]  in_lines,
    input wire logic [N_OUT-1:0] out_lines,
    input wire logic             meta_valid,
    input wire logic [63:0]      meta_time_stamp,
    input wire logic [31:0]      meta_trig_count,
    input wire logic [31:0]      meta_line_status,
    input wire logic [2:0]       meta_item_valid
);
    localparam int unsigned NL = N_IN + N_OUT;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_pulse; meta_valid |=> !meta_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("metadata strobe longer than one cycle");
    property p_trig; $rose(acq_trigger) |-> ##[2:7] meta_valid; endproperty
    a_trig: assert property (p_trig) else $error("no metadata after trigger");
    property p_ts_off; meta_valid && !meta_item_valid[0] |-> meta_time_stamp == 64'h0; endproperty
    a_ts_off: assert property (p_ts_off) else $error("stamp shown while off");
    property p_tc_off; meta_valid && !meta_item_valid[1] |-> meta_trig_count == 32'h0; endproperty
    a_tc_off: assert property (p_tc_off) else $error("count shown while off");
    property p_ls_off; meta_valid && !meta_item_valid[2] |-> meta_line_status == 32'h0; endproperty
    a_ls_off: assert property (p_ls_off) else $error("lines shown while off");
    property p_unused; (meta_line_status >> NL) == 32'h0; endproperty
    a_unused: assert property (p_unused) else $error("unused line bits set");
    property p_snap; meta_valid && meta_item_valid[2] |-> meta_line_status[NL-1:0] == {out_lines, in_lines};
    endproperty
    a_snap: assert property (p_snap) else $error("line snapshot wrong");
    property p_run; meta_valid && meta_item_valid[0] |-> meta_time_stamp != 64'h0; endproperty
    a_run: assert property (p_run) else $error("stamp counter not running");
endmodule
bind fmc_top fmc_top_chk #(.N_IN(N_IN), .N_OUT(N_OUT)) u_chk (.clk(clk), .rst_n(rst_n),
    .acq_trigger(acq_trigger), .in_lines(in_lines), .out_lines(out_lines), .meta_valid(meta_valid),
    .meta_time_stamp(meta_time_stamp), .meta_trig_count(meta_trig_count),
    .meta_line_status(meta_line_status), .meta_item_valid(meta_item_valid));
`default_nettype wire

// ---- fmc_cam_model.sv ----
// Acquisition side model driving trigger pins and line levels.
`timescale 1ns/1ns
`default_nettype none
module fmc_cam_model (
    input wire logic  clk,
    output logic       acq_trigger = 1'b0,
    output logic       ext_frame_trigger = 1'b0,
    output logic [3:0] in_lines = 4'h0,
    output logic [3:0] out_lines = 4'h0
);
    task automatic drive(input int k, input logic b);
        if (k == 0) acq_trigger <= b;
        else if (k == 1) ext_frame_trigger <= b;
        else in_lines[k-2] <= b;
    endtask
    // Levels stand four cycles each so the synchronizer sees them.
    task automatic pulse(input int k);
        @(posedge clk);
        drive(k, 1'b1);
        repeat (4) @(posedge clk);
        drive(k, 1'b0);
        repeat (4) @(posedge clk);
    endtask
    task automatic set_lines(input logic [3:0] i, input logic [3:0] o);
        @(posedge clk);
        in_lines <= i;
        out_lines <= o;
    endtask
endmodule
`default_nettype wire

// ---- tb_fmc_top.sv ----
// Testbench for the frame metadata counters.
`timescale 1ns/1ns
`default_nettype none
module tb_fmc_top;
    import fmc_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata, v, exp;
    logic        acq_trigger, ext_frame_trigger, meta_valid;
    logic [3:0]  in_lines, out_lines;
    logic [63:0] meta_time_stamp;
    logic [31:0] meta_trig_count, meta_line_status;
    logic [2:0]  meta_item_valid;
    int          failures = 0;
    int          checks = 0;
    always #10 clk = ~clk;
    fmc_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acq_trigger(acq_trigger),
        .ext_frame_trigger(ext_frame_trigger), .in_lines(in_lines), .out_lines(out_lines),
        .meta_valid(meta_valid), .meta_time_stamp(meta_time_stamp), .meta_trig_count(meta_trig_count),
        .meta_line_status(meta_line_status), .meta_item_valid(meta_item_valid));
    fmc_cam_model cam (.clk(clk), .acq_trigger(acq_trigger), .ext_frame_trigger(ext_frame_trigger),
        .in_lines(in_lines), .out_lines(out_lines));
    task automatic chk(input logic [63:0] got, input logic [63:0] want);
        checks++;
        if (got !== want) begin
            failures++;
            $display("CHECK FAILED t=%0t got %0h want %0h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic grab();
        fork cam.pulse(0); join_none
        repeat (20) begin
            @(posedge clk);
            #1 if (meta_valid === 1'b1) break;
        end
        chk(meta_valid, 1);
        repeat (8) @(posedge clk);
    endtask
    task automatic act(input int k);
        if (k == 2) wr(ADDR_CLR_CMD, 32'h1);
        else cam.pulse(k + 2);
    endtask
    task automatic t_reset();
        rd(ADDR_CLR_SRC, v);
        chk(v, FMC_CLR_OFF);
        rd(ADDR_TRIG_CNT, v);
        chk(v, 0);
        rd(ADDR_TICK_LO, exp);
        repeat (7) @(posedge clk);
        rd(ADDR_TICK_LO, v);
        chk(v - exp, 9);
    endtask
    task automatic t_items();
        wr(ADDR_ITEM_SEL, 32'(ITEM_TRIG_COUNT));
        wr(ADDR_ITEM_ON, 32'h1);
        rd(ADDR_ITEM_ON, v);
        chk(v, 0);
        wr(ADDR_MODE, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_ITEM_SEL, 32'(i));
            wr(ADDR_ITEM_ON, 32'h1);
        end
        rd(ADDR_ITEM_ON, v);
        chk(v, 7);
    endtask
    task automatic t_meta();
        cam.pulse(1);
        rd(ADDR_TRIG_CNT, v);
        chk(v, 0);
        wr(ADDR_TRIG_ON, 32'h1);
        repeat (3) cam.pulse(1);
        cam.set_lines(4'ha, 4'h5);
        rd(ADDR_TICK_LO, v);
        grab();
        chk(meta_trig_count, 3);
        chk(meta_item_valid, 3'h7);
        chk(meta_line_status, 32'h5a);
        chk(meta_time_stamp - v inside {[3:14]}, 1);
        wr(ADDR_MODE, 32'h0);
        grab();
        chk(meta_item_valid, 3'h0);
        chk(meta_trig_count, 0);
    endtask
    task automatic t_clear();
        cam.set_lines(4'h0, 4'h0);
        wr(ADDR_CNT_SEL, 32'(CNT_UNIT_FIRST));
        wr(ADDR_CNT_EVT, 32'(EVT_FRAME_TRIG));
        exp = 3;
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_CLR_SRC, 32'(s));
            cam.pulse(1);
            exp++;
            for (int k = 0; k < 3; k++)
                if (k != s) act(k);
            rd(ADDR_TRIG_CNT, v);
            chk(v, exp);
            if (s < 3) begin
                act(s);
                rd(ADDR_TRIG_CNT, v);
                chk(v, 0);
                exp = 0;
            end
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_items();
        t_meta();
        t_clear();
        end_of_test();
    end
endmodule
`default_nettype wire
